// ==== rtl/dprvd_axis.sv ====
// one deflection axis: ping-pong position registers and length output
// Overview of operation
// RULE1 - idle: toggle high, loads go to first register
// RULE2 - controller drives bus then pulses strobe low
// RULE3 - toggle high: strobe loads first register only
// RULE4 - controller skips loads for unchanged axis
// RULE5 - setup, load x, load y, then start
// RULE6 - invert-add subtract, complement when carry low
// RULE7 - sign flag is inverted carry
// RULE8 - twelve-bit length word: sign plus bits 0-10
// RULE9 - start pulse flips toggle, raises busy
// RULE10 - null pulse with busy: registers swap sources
// RULE11 - end-of-ramp copies first into second; code does so with toggle low, and copies second into first with toggle high
// RULE12 - copy happens in both axes together
// RULE13 - toggle low: strobe loads second register
// RULE14 - toggle steers strobe and null to registers
// RULE15 - twelve-bit registers: bus when idle, else other
// RULE16 - thirteen-bit result, top data bit dropped
// RULE17 - synchronise strobes, one enable per load
module dprvd_axis
  import dprvd_pkg::*;
#(
  parameter int WORD_W = DPRVD_WORD_W
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [11:0] graphic_data_bus_i,
  input wire logic load_strobe_n_i,
  input wire logic ramp_toggle_i,
  input wire logic position_busy_i,
  input wire logic position_null_pulse_i,
  output dprvd_len_t length_o,
  output dprvd_pair_t pair_o,
  output logic first_reg_clock_o,
  output logic second_reg_clock_o
);
  logic toggle_lvl;
  logic busy_lvl;
  logic strobe_fall;
  logic null_rise;
  logic [11:0] bus_meta_ff;
  logic [11:0] bus_sync_ff;
  logic [11:0] first_ff;
  logic [11:0] second_ff;
  logic [11:0] nxt_first;
  logic [11:0] nxt_second;
  logic first_clk_ff;
  logic second_clk_ff;
  logic nxt_first_clk;
  logic nxt_second_clk;
  dprvd_len_t len_ff;
  dprvd_len_t nxt_len;
  logic [11:0] magnitude;
  logic carry;

  // strobe is active low, so its falling edge is the load event
  dprvd_edge_sync u_strobe
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(load_strobe_n_i),
    .rst_level_i(1'b0),
    .level_o(),
    .rise_o(),
    .fall_o(strobe_fall) // RULE17
  );

  dprvd_edge_sync u_null
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(position_null_pulse_i),
    .rst_level_i(1'b0),
    .level_o(),
    .rise_o(null_rise), // RULE17
    .fall_o()
  );

  // toggle is synchronised inverted so reset shows its idle-high state
  dprvd_edge_sync u_toggle
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(~ramp_toggle_i),
    .rst_level_i(1'b1),
    .level_o(toggle_lvl), // RULE1
    .rise_o(),
    .fall_o()
  );

  dprvd_edge_sync u_busy
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(position_busy_i),
    .rst_level_i(1'b0),
    .level_o(busy_lvl),
    .rise_o(),
    .fall_o()
  );

  dprvd_delta u_delta
  (
    .first_reg_word_i(first_ff),
    .second_reg_word_i(second_ff),
    .magnitude_o(magnitude),
    .carry_o(carry)
  );

  // next values of the bus sampler and the steering result
  logic [11:0] nxt_bus_meta;
  logic [11:0] nxt_bus_sync;
  logic [1:0] steer;

  // clock generator: which register a load or a null event clocks;
  // a null copies toward the register that still holds the old endpoint,
  // so the endpoint just reached survives into the next move
  function automatic logic [1:0] steer_clocks(
    input logic toggle,
    input logic load_ev,
    input logic null_ev
  );
    logic [1:0] clks;
    clks = 2'b00;
    if (toggle)
    begin
      clks[0] = load_ev | null_ev; // RULE3 RULE14
    end
    else
    begin
      clks[1] = load_ev | null_ev; // RULE11 RULE13 RULE14
    end
    return clks;
  endfunction

  // busy high turns each register's source to the other register
  function automatic logic [11:0] pick_source(
    input logic busy,
    input logic [11:0] other_word,
    input logic [11:0] bus_word
  );
    logic [11:0] src;
    src = busy ? other_word : bus_word; // RULE10 RULE15
    return src;
  endfunction

  // bus sampler: two stages, so the word seen lags the pin by two edges
  always_comb
  begin
    nxt_bus_meta = graphic_data_bus_i; // RULE2
    nxt_bus_sync = bus_meta_ff;
  end

  // bus word must be stable before the strobe; it settles ahead of the edge
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bus_meta_ff <= DPRVD_REG_RST;
      bus_sync_ff <= DPRVD_REG_RST;
    end
    else
    begin
      bus_meta_ff <= nxt_bus_meta;
      bus_sync_ff <= nxt_bus_sync;
    end
  end

  // clock generator steering and register source selection
  always_comb
  begin
    steer = steer_clocks(toggle_lvl, strobe_fall, null_rise);
    nxt_first_clk = steer[0];
    nxt_second_clk = steer[1];
    nxt_first = first_ff;
    nxt_second = second_ff;
    if (nxt_first_clk)
    begin
      nxt_first = pick_source(busy_lvl, second_ff, bus_sync_ff); // RULE15
    end
    if (nxt_second_clk)
    begin
      nxt_second = pick_source(busy_lvl, first_ff, bus_sync_ff); // RULE11 RULE12
    end
  end

  // registers; contents after reset are don't-care in hardware, zero here
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      first_ff <= DPRVD_REG_RST;
      second_ff <= DPRVD_REG_RST;
      first_clk_ff <= 1'b0;
      second_clk_ff <= 1'b0;
    end
    else
    begin
      first_ff <= nxt_first;
      second_ff <= nxt_second;
      first_clk_ff <= nxt_first_clk;
      second_clk_ff <= nxt_second_clk;
    end
  end

  // length word; the top data bit of the magnitude is never forwarded
  always_comb
  begin
    nxt_len.sign_flag = ~carry; // RULE7
    nxt_len.length_bits = magnitude[10:0]; // RULE8 RULE16
  end

  // registered so the ramp side sees a word free of subtracter glitches,
  // at the cost of one cycle after each register load
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      len_ff <= '0;
    end
    else
    begin
      len_ff <= nxt_len; // RULE6
    end
  end

  assign length_o = len_ff;
  assign pair_o = '{first_reg_word: first_ff, second_reg_word: second_ff};
  assign first_reg_clock_o = first_clk_ff;
  assign second_reg_clock_o = second_clk_ff;
endmodule

// ==== pkg/dprvd_pkg.sv ====
// shared constants and carrier types for the position register delta block
package dprvd_pkg;
  localparam int DPRVD_WORD_W = 12;
  localparam int DPRVD_LEN_W = 11;
  localparam int DPRVD_SYNC_STAGES = 2;
  localparam logic [11:0] DPRVD_REG_RST = 12'h000;
  localparam logic DPRVD_TOGGLE_RST = 1'b1;
  localparam logic DPRVD_BUSY_RST = 1'b0;

  // length word handed to the ramp generator
  typedef struct packed {
    logic sign_flag;
    logic [10:0] length_bits;
  } dprvd_len_t;

  // position register pair
  typedef struct packed {
    logic [11:0] first_reg_word;
    logic [11:0] second_reg_word;
  } dprvd_pair_t;
endpackage

// ==== rtl/dprvd_edge_sync.sv ====
// two-stage synchroniser with rising and falling edge pulses
module dprvd_edge_sync
  import dprvd_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic async_i,
  input wire logic rst_level_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_last;

  // first stage only feeds second stage
  always_comb
  begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  // flops reset to zero; the level shown at reset is a constant chosen by the instance
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  assign level_o = sync_ff ^ rst_level_i;
  assign rise_o = (sync_ff & ~last_ff) ^ 1'b0;
  assign fall_o = ~sync_ff & last_ff;
endmodule

// ==== rtl/dprvd_delta.sv ====
// subtracter with true/complement stage producing length and sign
module dprvd_delta
  import dprvd_pkg::*;
(
  input wire logic [11:0] first_reg_word_i,
  input wire logic [11:0] second_reg_word_i,
  output logic [11:0] magnitude_o,
  output logic carry_o
);
  logic [12:0] sum;

  // invert first register and add to second; 13-bit result with carry
  always_comb
  begin
    sum = {1'b0, ~first_reg_word_i} + {1'b0, second_reg_word_i}; // RULE6 RULE16
    carry_o = sum[12];
    magnitude_o = carry_o ? sum[11:0] : ~sum[11:0]; // RULE6
  end
endmodule

// ==== testbench/dprvd_axis_asserts.sv ====
// checker for the axis block ports
module dprvd_axis_asserts
  import dprvd_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [11:0] graphic_data_bus_i,
  input wire logic load_strobe_n_i,
  input wire logic ramp_toggle_i,
  input wire logic position_busy_i,
  input wire logic position_null_pulse_i,
  input wire dprvd_len_t length_o,
  input wire dprvd_pair_t pair_o,
  input wire logic first_reg_clock_o,
  input wire logic second_reg_clock_o
);
  logic c1, c2, bz;
  logic [11:0] fw, sw;
  // short aliases keep each property on one line
  assign {c1, c2, bz} = {first_reg_clock_o, second_reg_clock_o, position_busy_i};
  assign {fw, sw} = pair_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_first_once: assert property (c1 |=> !c1)
    else $error("first pulse too long");
  a_second_once: assert property (c2 |=> !c2)
    else $error("second pulse too long");
  a_first_hold: assert property (!c1 |-> $stable(fw))
    else $error("first changed unclocked");
  a_second_hold: assert property (!c2 |-> $stable(sw))
    else $error("second changed unclocked");
  a_first_bus: assert property (c1 && !bz |-> fw == graphic_data_bus_i)
    else $error("first bus load wrong");
  a_second_bus: assert property (c2 && !bz |-> sw == graphic_data_bus_i)
    else $error("second bus load wrong");
  a_first_copy: assert property (c1 && bz |-> fw == sw)
    else $error("first copy wrong");
  a_second_copy: assert property (c2 && bz |-> sw == fw)
    else $error("second copy wrong");
  a_clocks_exclusive: assert property (!(c1 && c2))
    else $error("both register clocks at once");
endmodule
bind dprvd_axis dprvd_axis_asserts i_chk (.*);

// ==== testbench/dprvd_ramp_model.sv ====
// ramp side stand-in: toggle, busy and null pulse
module dprvd_ramp_model
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic go_i,
  output logic tg_o,
  output logic bz_o,
  output logic nl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] n_ff;
  // null sits well inside busy so the copy sees busy high
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      {tg_o, bz_o, nl_o, n_ff} <= 8'h80;
    else
    begin
      tg_o <= tg_o ^ go_i;
      n_ff <= (go_i || n_ff != 5'h00) && n_ff != 5'h14 ? n_ff + 5'h01 : 5'h00;
      bz_o <= go_i || (n_ff != 5'h00 && n_ff != 5'h14);
      nl_o <= n_ff > 5'h09 && n_ff < 5'h0E;
    end
endmodule

// ==== testbench/tb_dual_position_register_vector_delta.sv ====
// bench: loads, ramps and end-of-ramp copies on one axis
module tb_dual_position_register_vector_delta;
  timeunit 1ns;
  timeprecision 1ps;
  import dprvd_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic load_strobe_n_i = 1'b1;
  logic go = 1'b0;
  logic [11:0] graphic_data_bus_i = 12'h000;
  logic ramp_toggle_i, position_busy_i, position_null_pulse_i;
  logic first_reg_clock_o, second_reg_clock_o;
  dprvd_len_t length_o;
  dprvd_pair_t pair_o;
  logic [37:0] st;
  int n_errors = 0;
  int tests_run = 0;
  assign st = {ramp_toggle_i, position_busy_i, length_o, pair_o};
  always #2.5 clk_i = ~clk_i;
  dprvd_ramp_model i_ramp (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(go), .tg_o(ramp_toggle_i),
    .bz_o(position_busy_i), .nl_o(position_null_pulse_i));
  dprvd_axis i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .graphic_data_bus_i(graphic_data_bus_i),
    .load_strobe_n_i(load_strobe_n_i), .ramp_toggle_i(ramp_toggle_i),
    .position_busy_i(position_busy_i), .position_null_pulse_i(position_null_pulse_i),
    .length_o(length_o), .pair_o(pair_o), .first_reg_clock_o(first_reg_clock_o),
    .second_reg_clock_o(second_reg_clock_o));
  // counts, verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // toggle, busy, length and pair compared as one word
  task automatic check(input logic [37:0] seen, input logic [37:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch state exp %h seen %h", exp, seen);
    end
    $display("test %0d done", tests_run);
  endtask
  // bus settles two cycles before the strobe falls and stays
  task automatic load(input logic [11:0] w);
    @(posedge clk_i) graphic_data_bus_i <= w;
    repeat (2) @(posedge clk_i);
    load_strobe_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    load_strobe_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
  // start pulse, then a bounded wait for busy to drop
  task automatic ramp();
    int i;
    @(posedge clk_i) go <= 1'b1;
    @(posedge clk_i) go <= 1'b0;
    repeat (2) @(posedge clk_i);
    for (i = 0; i < 99 && position_busy_i !== 1'b0; i++)
      @(posedge clk_i);
    if (i == 99)
      n_errors++;
    if (i == 99)
      wrap_up();
    repeat (4) @(posedge clk_i);
  endtask
  // reset, load, ramp, reload, ramp, back-to-back loads, two ramps
  initial
  begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    load(12'h005);
    check(st, {2'b10, 12'h805, 24'h005000});
    ramp();
    check(st, {2'b00, 12'h800, 24'h005005});
    load(12'hFFB);
    check(st, {2'b00, 12'h7F5, 24'h005FFB});
    ramp();
    check(st, {2'b10, 12'h800, 24'hFFBFFB});
    load(12'h123);
    load(12'h0F0);
    check(st, {2'b10, 12'h70A, 24'h0F0FFB});
    ramp();
    check(st, {2'b00, 12'h800, 24'h0F00F0});
    ramp();
    check(st, {2'b10, 12'h800, 24'h0F00F0});
    wrap_up();
  end
endmodule
